// ===== rtl/tcc_pkg.sv
// Purpose: constants and types of the timer capture/compare block
// Assumes: AHB-Lite word access, byte addresses below
// Notes:   all fields sit in the low bits of a word; upper bits read 0
package tcc_pkg;
  // ------------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_COUNT = 8'h04;
  localparam logic [7:0] OFS_MODULO = 8'h08;
  localparam logic [7:0] OFS_CH0_SC = 8'h0C;
  localparam logic [7:0] OFS_CH0_HIGH = 8'h10;
  localparam logic [7:0] OFS_CH0_LOW = 8'h14;
  localparam logic [7:0] OFS_CH1_SC = 8'h18;
  localparam logic [7:0] OFS_CH1_HIGH = 8'h1C;
  localparam logic [7:0] OFS_CH1_LOW = 8'h20;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h24;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h28;
  localparam logic [7:0] OFS_CH_STRIDE = 8'h0C;
  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int CTRL_PS_LSB = 0;
  localparam int CTRL_RESET_BIT = 4;
  localparam int CTRL_STOP_BIT = 5;
  localparam int SC_TOV_BIT = 1;
  localparam int SC_ELS_A_BIT = 2;
  localparam int SC_ELS_B_BIT = 3;
  localparam int SC_MODE_A_BIT = 4;
  localparam int SC_IRQ_EN_BIT = 6;
  localparam int SC_FLAG_BIT = 7;
  localparam int STAT_OVF_BIT = 0;
  localparam int STAT_CH0_BIT = 1;
  localparam int NUM_CHAN = 2;
  localparam int NUM_STAT = 3;
  // ------------------------------------------------------------------
  // reset values and counts
  // ------------------------------------------------------------------
  localparam logic [2:0] PS_RESET = 3'h0;
  localparam logic [2:0] PS_MAX = 3'h6;
  localparam logic STOP_RESET = 1'b1;
  localparam logic [15:0] MODULO_RESET = 16'hFFFF;
  localparam logic [15:0] VALUE_RESET = 16'h0000;
  localparam logic [2:0] MASK_RESET = 3'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef struct packed {
    logic irq_en;
    logic mode_a;
    logic els_b;
    logic els_a;
    logic tov;
  } tcc_chan_ctrl_t;
  localparam tcc_chan_ctrl_t CHAN_CTRL_RESET = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
endpackage : tcc_pkg

// ===== rtl/tcc_timer.sv
// Purpose: two-channel capture/compare timer behind an AHB-Lite slave
// Assumes: 50 MHz clk_i, channel pins asynchronous to clk_i
// Notes:   zero-wait-state slave; compare values are unbuffered
//
// Summary of operation
// (R1) prescale_select picks one of seven clock rates derived from the bus clock.
// (R2) active capture edge copies the counter into the channel value pair.
// (R3) edge_level_select chooses rising, falling or either edge for capture.
// (R4) an input capture sets the channel event flag and may interrupt.
// (R5) counter equal to compare value sets, clears or toggles the pin.
// (R6) an output compare match sets the channel event flag and may interrupt.
// (R7) unbuffered compare writes overwrite the active value at once.
// (R8) unsynchronised compare writes may misbehave two overflow periods; not corrected.
// (R9) a value written behind the counter gives no compare that period.
// (R10) compare interrupt comes at the match ending the current pulse.
// (R11) software writes smaller compare values from the compare interrupt routine.
// (R12) overflow interrupt comes at the end of each counter period.
// (R13) software writes larger compare values from the overflow interrupt routine.
// (R14) overflow_toggle_bit set toggles the output at each overflow.
// (R15) edge_level_select 1:0 clears, 1:1 sets the output on compare.
// (R16) counter and values are 16 bits in two bytes, exact equality.
`timescale 1ns/100ps
module tcc_timer (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic [1:0] chan_pin_i,
  output logic [1:0] chan_pin_o,
  output logic [1:0] chan_pin_oe_o,
  output logic irq_o
);
  // ------------------------------------------------------------------
  // storage shared by all sections
  // ------------------------------------------------------------------
  // the channel count sizes the arrays below, so it is declared first
  localparam int NUM_CHAN_L = tcc_pkg::NUM_CHAN;

  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic [31:0] hrdata_reg;
  logic addr_ok;
  logic rd_take;
  logic [7:0] rd_addr;
  logic [31:0] rd_mux;
  logic [2:0] prescale_select_reg;
  logic stop_reg;
  logic [15:0] count_reg;
  logic [15:0] modulo_reg;
  logic [2:0] status_reg;
  logic [2:0] mask_reg;
  logic [15:0] chan_value_pair [NUM_CHAN_L];
  tcc_pkg::tcc_chan_ctrl_t chan_ctrl_reg [NUM_CHAN_L];
  logic [1:0] chan_event;
  logic [1:0] pin_reg;
  logic [1:0] pin_oe_reg;
  logic irq_reg;

  // ------------------------------------------------------------------
  // bus slave
  // ------------------------------------------------------------------
  // unused size bits: only whole-word transfers are issued
  assign addr_ok = hsel_i && hready_i && htrans_i[1];
  assign rd_take = addr_ok && !hwrite_i;
  assign rd_addr = haddr_i[7:0];

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end
    else
    begin
      wr_pend_reg <= addr_ok && hwrite_i;
      wr_addr_reg <= haddr_i[7:0];
    end
  end

  function automatic logic [7:0] sc_byte(input tcc_pkg::tcc_chan_ctrl_t c, input logic flag);
    logic [7:0] b;
    b = 8'h00;
    b[tcc_pkg::SC_FLAG_BIT] = flag;
    b[tcc_pkg::SC_IRQ_EN_BIT] = c.irq_en;
    b[tcc_pkg::SC_MODE_A_BIT] = c.mode_a;
    b[tcc_pkg::SC_ELS_B_BIT] = c.els_b;
    b[tcc_pkg::SC_ELS_A_BIT] = c.els_a;
    b[tcc_pkg::SC_TOV_BIT] = c.tov;
    return b;
  endfunction : sc_byte

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (rd_addr)
      tcc_pkg::OFS_CTRL: rd_mux = {26'h0, stop_reg, 2'h0, prescale_select_reg};
      tcc_pkg::OFS_COUNT: rd_mux = {16'h0, count_reg};
      tcc_pkg::OFS_MODULO: rd_mux = {16'h0, modulo_reg};
      tcc_pkg::OFS_CH0_SC: rd_mux = {24'h0, sc_byte(chan_ctrl_reg[0], status_reg[1])};
      tcc_pkg::OFS_CH0_HIGH: rd_mux = {24'h0, chan_value_pair[0][15:8]};
      tcc_pkg::OFS_CH0_LOW: rd_mux = {24'h0, chan_value_pair[0][7:0]};
      tcc_pkg::OFS_CH1_SC: rd_mux = {24'h0, sc_byte(chan_ctrl_reg[1], status_reg[2])};
      tcc_pkg::OFS_CH1_HIGH: rd_mux = {24'h0, chan_value_pair[1][15:8]};
      tcc_pkg::OFS_CH1_LOW: rd_mux = {24'h0, chan_value_pair[1][7:0]};
      tcc_pkg::OFS_IRQ_STATUS: rd_mux = {29'h0, status_reg};
      tcc_pkg::OFS_IRQ_MASK: rd_mux = {29'h0, mask_reg};
      // unmapped offsets read as zero
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // read data is latched at the address phase so it comes from a flop
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      hrdata_reg <= 32'h0000_0000;
    else if (rd_take)
      hrdata_reg <= rd_mux;
  end

  assign hrdata_o = hrdata_reg;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;

  // ------------------------------------------------------------------
  // control, modulo and mask registers
  // ------------------------------------------------------------------
  logic ctrl_wr;
  logic count_clear;
  assign ctrl_wr = wr_pend_reg && (wr_addr_reg == tcc_pkg::OFS_CTRL);
  // the reset bit is a pulse: acted on in the write cycle, never stored
  assign count_clear = ctrl_wr && hwdata_i[tcc_pkg::CTRL_RESET_BIT];

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      prescale_select_reg <= tcc_pkg::PS_RESET;
      // held stopped out of reset so software can set it up first
      stop_reg <= tcc_pkg::STOP_RESET;
      modulo_reg <= tcc_pkg::MODULO_RESET;
      mask_reg <= tcc_pkg::MASK_RESET;
    end
    else if (wr_pend_reg)
    begin
      if (ctrl_wr)
      begin
        prescale_select_reg <= hwdata_i[tcc_pkg::CTRL_PS_LSB +: 3]; // R1
        stop_reg <= hwdata_i[tcc_pkg::CTRL_STOP_BIT];
      end
      if (wr_addr_reg == tcc_pkg::OFS_MODULO)
        modulo_reg <= hwdata_i[15:0];
      if (wr_addr_reg == tcc_pkg::OFS_IRQ_MASK)
        mask_reg <= hwdata_i[2:0];
    end
  end

  // ------------------------------------------------------------------
  // prescaler and counter
  // ------------------------------------------------------------------
  logic [5:0] div_reg;
  logic [5:0] div_mask;
  logic [2:0] ps_eff;
  logic tick;
  logic overflow;

  // code 7 is not a rate of its own; it runs at the slowest of the seven
  assign ps_eff = (prescale_select_reg > tcc_pkg::PS_MAX) ? tcc_pkg::PS_MAX
                                                          : prescale_select_reg;
  assign div_mask = 6'((7'h01 << ps_eff) - 7'h01); // R1
  assign tick = !stop_reg && ((div_reg & div_mask) == div_mask); // R1
  assign overflow = tick && (count_reg == modulo_reg);

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      div_reg <= 6'h00;
      count_reg <= 16'h0000;
    end
    // a counter reset beats a running count and also clears the divider,
    // so the first tick after it is a full prescale period away
    else if (count_clear)
    begin
      div_reg <= 6'h00;
      count_reg <= 16'h0000;
    end
    else if (!stop_reg)
    begin
      div_reg <= div_reg + 6'h01;
      if (overflow)
        count_reg <= 16'h0000;
      else if (tick)
        count_reg <= count_reg + 16'h0001;
    end
  end

  // ------------------------------------------------------------------
  // channels
  // ------------------------------------------------------------------
  logic [1:0] pin_meta_reg;
  logic [1:0] pin_sync_reg;
  logic [1:0] pin_prev_reg;

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      // pins idle low, so this reset level gives no false edge afterwards
      pin_meta_reg <= 2'h0;
      pin_sync_reg <= 2'h0;
      pin_prev_reg <= 2'h0;
    end
    else
    begin
      pin_meta_reg <= chan_pin_i;
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  for (genvar ch = 0; ch < NUM_CHAN_L; ch++)
  begin : g_chan
    localparam logic [7:0] SC_A = 8'(tcc_pkg::OFS_CH0_SC + 8'(ch) * tcc_pkg::OFS_CH_STRIDE);
    localparam logic [7:0] HI_A = 8'(tcc_pkg::OFS_CH0_HIGH + 8'(ch) * tcc_pkg::OFS_CH_STRIDE);
    localparam logic [7:0] LO_A = 8'(tcc_pkg::OFS_CH0_LOW + 8'(ch) * tcc_pkg::OFS_CH_STRIDE);
    logic rise;
    logic fall;
    logic capture;
    logic match;
    logic toggled;
    tcc_pkg::tcc_chan_ctrl_t c;

    assign c = chan_ctrl_reg[ch];
    assign rise = pin_sync_reg[ch] && !pin_prev_reg[ch];
    assign fall = !pin_sync_reg[ch] && pin_prev_reg[ch];
    // 0:1 rising, 1:0 falling, 1:1 either; 0:0 disables capture
    assign capture = !c.mode_a && ((c.els_a && rise) || (c.els_b && fall)); // R3
    // equality is tested only on a counter step, so a value the counter
    // has already passed gives no match until the next period
    assign match = c.mode_a && tick && (count_reg == chan_value_pair[ch]); // R16 R9
    assign chan_event[ch] = capture || match; // R4 R6 R10

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
      if (!resetn_i)
        chan_ctrl_reg[ch] <= tcc_pkg::CHAN_CTRL_RESET;
      else if (wr_pend_reg && (wr_addr_reg == SC_A))
      begin
        chan_ctrl_reg[ch].irq_en <= hwdata_i[tcc_pkg::SC_IRQ_EN_BIT];
        chan_ctrl_reg[ch].mode_a <= hwdata_i[tcc_pkg::SC_MODE_A_BIT];
        chan_ctrl_reg[ch].els_b <= hwdata_i[tcc_pkg::SC_ELS_B_BIT];
        chan_ctrl_reg[ch].els_a <= hwdata_i[tcc_pkg::SC_ELS_A_BIT];
        chan_ctrl_reg[ch].tov <= hwdata_i[tcc_pkg::SC_TOV_BIT];
      end
    end

    // software write and capture never shadow: the last one wins, and a
    // bus write beats a capture in the same cycle; mistimed writes are
    // software's to avoid
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
      if (!resetn_i)
        chan_value_pair[ch] <= tcc_pkg::VALUE_RESET;
      else if (wr_pend_reg && (wr_addr_reg == HI_A))
        chan_value_pair[ch][15:8] <= hwdata_i[7:0]; // R7 R8 R16
      else if (wr_pend_reg && (wr_addr_reg == LO_A))
        chan_value_pair[ch][7:0] <= hwdata_i[7:0]; // R7 R16
      else if (capture)
        chan_value_pair[ch] <= count_reg; // R2
    end

    assign toggled = (overflow && c.tov) ? !pin_reg[ch] : pin_reg[ch]; // R14

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
      if (!resetn_i)
      begin
        pin_reg[ch] <= 1'b0;
        pin_oe_reg[ch] <= 1'b0;
      end
      else
      begin
        // els 00 hands the pin back to the outside; the output flop may
        // still follow overflow toggles but nothing is driven
        pin_oe_reg[ch] <= c.mode_a && (c.els_a || c.els_b);
        if (!c.mode_a)
          pin_reg[ch] <= 1'b0;
        else if (match && c.els_b)
          pin_reg[ch] <= c.els_a; // R5 R15
        else if (match && c.els_a)
          pin_reg[ch] <= !toggled; // R5
        else
          pin_reg[ch] <= toggled; // R14
      end
    end
  end

  assign chan_pin_o = pin_reg;
  assign chan_pin_oe_o = pin_oe_reg;

  // ------------------------------------------------------------------
  // interrupt status
  // ------------------------------------------------------------------
  logic [2:0] stat_set;
  logic [2:0] eff_mask;
  logic stat_rd;

  assign stat_set = {chan_event, overflow}; // R12 R4 R6
  assign stat_rd = rd_take && (rd_addr == tcc_pkg::OFS_IRQ_STATUS);
  assign eff_mask = mask_reg & {chan_ctrl_reg[1].irq_en, chan_ctrl_reg[0].irq_en, 1'b1};
  // a channel needs both its mask bit and its own enable bit to interrupt

  // a new event in the clearing cycle survives the read
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      status_reg <= 3'h0;
    else if (stat_rd)
      status_reg <= stat_set;
    else
      status_reg <= status_reg | stat_set;
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      irq_reg <= 1'b0;
    else
      irq_reg <= |(status_reg & eff_mask); // R4 R6 R12
  end

  assign irq_o = irq_reg;
endmodule : tcc_timer

// ===== bench/tcc_properties.sv
// Purpose: bus and pin properties of the capture/compare timer
// Assumes: zero-wait slave, one clock domain
// Notes:   bound to every tcc_timer instance
`timescale 1ns/100ps
module tcc_properties (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic [1:0] chan_pin_o,
  input wire logic [1:0] chan_pin_oe_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);
  logic take;
  logic [2:0] wr_age_reg;
  assign take = hsel_i && hready_i && htrans_i[1];
  // saturating age of the last write, so an old write never looks recent
  always_ff @(posedge clk_i or negedge resetn_i)
    if (!resetn_i)
      wr_age_reg <= 3'h7;
    else if (take && hwrite_i)
      wr_age_reg <= 3'h0;
    else if (wr_age_reg != 3'h7)
      wr_age_reg <= wr_age_reg + 3'h1;
  sequence s_read(logic [7:0] ofs);
    take && !hwrite_i && haddr_i[7:0] == ofs;
  endsequence
  property p_zero_wait;
    hreadyout_o && !hresp_o;
  endproperty
  a_zero_wait: assert property (p_zero_wait) else $error("wait state or error response");
  property p_upper_zero;
    take && !hwrite_i |=> hrdata_o[31:16] == 16'h0000;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("read data above bit 15");
  property p_unmapped;
    s_read(8'h2C) |=> hrdata_o == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_sc_spare;
    s_read(tcc_pkg::OFS_CH1_SC) |=> hrdata_o[31:8] == 24'h000000 && !hrdata_o[5];
  endproperty
  a_sc_spare: assert property (p_sc_spare) else $error("spare status bits set");
  property p_mask_bits;
    s_read(tcc_pkg::OFS_IRQ_MASK) |=> hrdata_o[31:3] == 29'h0;
  endproperty
  a_mask_bits: assert property (p_mask_bits) else $error("mask spare bits set");
  property p_oe_cause;
    $changed(chan_pin_oe_o) |-> wr_age_reg <= 3'h3;
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("pin enable moved without write");
  property p_irq_reset;
    $rose(resetn_i) |-> !irq_o ##1 !irq_o;
  endproperty
  a_irq_reset: assert property (p_irq_reset) else $error("interrupt right after reset");
  property p_pin_cause;
    $changed(chan_pin_o) |->
      ((chan_pin_o ^ $past(chan_pin_o)) & ~($past(chan_pin_oe_o) | chan_pin_oe_o)) == 2'b00;
  endproperty
  a_pin_cause: assert property (p_pin_cause) else $error("undriven pin moved");
endmodule : tcc_properties
bind tcc_timer tcc_properties u_props (.clk_i(clk_i), .resetn_i(resetn_i), .hsel_i(hsel_i),
  .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i),
  .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
  .chan_pin_o(chan_pin_o), .chan_pin_oe_o(chan_pin_oe_o), .irq_o(irq_o));

// ===== bench/tcc_pin_model.sv
// Purpose: far side of the two channel pins
// Assumes: an outside source drives each pin whenever the timer does not
// Notes:   the timer's own drive wins, so capture sees the real wire
`timescale 1ns/100ps
module tcc_pin_model (
  input wire logic [1:0] stim_i,
  input wire logic [1:0] pin_o_i,
  input wire logic [1:0] oe_i,
  output logic [1:0] pin_i_o
);
  assign pin_i_o = (oe_i & pin_o_i) | (~oe_i & stim_i);
endmodule : tcc_pin_model

// ===== bench/tb_top.sv
// Purpose: self-checking bench of the capture/compare timer
// Assumes: zero-wait AHB-Lite slave, prescale 0 gives one tick a cycle
// Notes:   count checks allow two ticks of slack for bus latency
`timescale 1ns/100ps
module tb_top;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic hsel_i = 1'b0;
  logic [31:0] haddr_i = 32'h0000_0000;
  logic [1:0] htrans_i = 2'h0;
  logic hwrite_i = 1'b0;
  logic [31:0] hwdata_i = 32'h0000_0000;
  logic [31:0] hrdata_o;
  logic hreadyout_o;
  logic irq_o;
  logic [1:0] chan_pin_i;
  logic [1:0] chan_pin_o;
  logic [1:0] chan_pin_oe_o;
  logic [1:0] stim = 2'h0;
  logic [31:0] q;
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;
  always #10 clk_i = ~clk_i;
  tcc_timer u_dut (.clk_i(clk_i), .resetn_i(resetn_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i),
    .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(),
    .chan_pin_i(chan_pin_i), .chan_pin_o(chan_pin_o), .chan_pin_oe_o(chan_pin_oe_o),
    .irq_o(irq_o));
  tcc_pin_model u_pins (.stim_i(stim), .pin_o_i(chan_pin_o), .oe_i(chan_pin_oe_o),
    .pin_i_o(chan_pin_i));
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 10000)
    begin
      errors++;
      finish_test();
    end
  end
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  // one single transfer; entered right after a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel_i <= 1'b1;
    haddr_i <= {24'h0, a};
    htrans_i <= tcc_pkg::HTRANS_NONSEQ;
    hwrite_i <= w;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    q = hrdata_o;
  endtask : xfer
  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(name, q, exp);
  endtask : rd_chk
  task automatic wait_pin(input logic lvl);
    int n;
    n = 0;
    while (chan_pin_o[1] !== lvl && n < 300)
    begin
      @(posedge clk_i);
      n++;
    end
    chk("pin1", {31'h0, chan_pin_o[1]}, {31'h0, lvl});
  endtask : wait_pin
  task automatic edge0(input logic lvl, input logic [31:0] exp);
    stim[0] <= lvl;
    repeat (6) @(posedge clk_i);
    rd_chk("capture status", tcc_pkg::OFS_IRQ_STATUS, exp);
  endtask : edge0
  task automatic t_reset;
    xfer(1'b1, tcc_pkg::OFS_COUNT, 32'h0000_1234);
    rd_chk("ctrl", tcc_pkg::OFS_CTRL, 32'h0000_0020);
    rd_chk("count", tcc_pkg::OFS_COUNT, 32'h0000_0000);
    rd_chk("modulo", tcc_pkg::OFS_MODULO, 32'h0000_FFFF);
    rd_chk("sc1", tcc_pkg::OFS_CH1_SC, 32'h0000_0000);
    rd_chk("mask", tcc_pkg::OFS_IRQ_MASK, 32'h0000_0000);
    rd_chk("unmapped", 8'h2C, 32'h0000_0000);
    $display("reset test done");
  endtask : t_reset
  task automatic t_prescale;
    int exp;
    for (int ps = 0; ps < 8; ps++)
    begin
      xfer(1'b1, tcc_pkg::OFS_CTRL, 32'h30 | ps);
      xfer(1'b1, tcc_pkg::OFS_CTRL, ps);
      repeat (256) @(posedge clk_i);
      xfer(1'b1, tcc_pkg::OFS_CTRL, 32'h20 | ps);
      xfer(1'b0, tcc_pkg::OFS_COUNT, 32'h0);
      // code 7 runs at the slowest of the seven rates
      exp = 258 >> ((ps > 6) ? 6 : ps);
      chk("rate", {31'h0, q >= exp - 2 && q <= exp + 2}, 32'h1);
    end
    $display("prescale test done");
  endtask : t_prescale
  task automatic t_capture;
    logic [31:0] c;
    xfer(1'b1, tcc_pkg::OFS_CTRL, 32'h0000_0000);
    repeat (100) @(posedge clk_i);
    xfer(1'b1, tcc_pkg::OFS_CTRL, 32'h0000_0020);
    xfer(1'b0, tcc_pkg::OFS_COUNT, 32'h0);
    c = q;
    xfer(1'b1, tcc_pkg::OFS_CH0_SC, 32'h0000_0044);
    stim[0] <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk("masked irq", {31'h0, irq_o}, 32'h0);
    xfer(1'b1, tcc_pkg::OFS_IRQ_MASK, 32'h0000_0002);
    repeat (2) @(posedge clk_i);
    chk("capture irq", {31'h0, irq_o}, 32'h1);
    rd_chk("cap low", tcc_pkg::OFS_CH0_LOW, {24'h0, c[7:0]});
    rd_chk("cap high", tcc_pkg::OFS_CH0_HIGH, {24'h0, c[15:8]});
    rd_chk("status", tcc_pkg::OFS_IRQ_STATUS, 32'h0000_0002);
    repeat (2) @(posedge clk_i);
    chk("cleared irq", {31'h0, irq_o}, 32'h0);
    edge0(1'b0, 32'h0);
    xfer(1'b1, tcc_pkg::OFS_CH0_SC, 32'h0000_0048);
    edge0(1'b1, 32'h0);
    edge0(1'b0, 32'h2);
    $display("capture test done");
  endtask : t_capture
  task automatic t_compare;
    xfer(1'b1, tcc_pkg::OFS_MODULO, 32'h0000_0040);
    xfer(1'b1, tcc_pkg::OFS_CTRL, 32'h0000_0030);
    xfer(1'b1, tcc_pkg::OFS_CH1_HIGH, 32'h0000_0000);
    xfer(1'b1, tcc_pkg::OFS_CH1_LOW, 32'h0000_0010);
    xfer(1'b1, tcc_pkg::OFS_CH1_SC, 32'h0000_005C);
    xfer(1'b1, tcc_pkg::OFS_IRQ_MASK, 32'h0000_0005);
    xfer(1'b0, tcc_pkg::OFS_IRQ_STATUS, 32'h0);
    xfer(1'b1, tcc_pkg::OFS_CTRL, 32'h0000_0000);
    wait_pin(1'b1);
    chk("oe1", {31'h0, chan_pin_oe_o[1]}, 32'h1);
    repeat (2) @(posedge clk_i);
    chk("compare irq", {31'h0, irq_o}, 32'h1);
    rd_chk("status", tcc_pkg::OFS_IRQ_STATUS, 32'h0000_0004);
    xfer(1'b1, tcc_pkg::OFS_CH1_SC, 32'h0000_0058);
    wait_pin(1'b0);
    xfer(1'b1, tcc_pkg::OFS_CH1_SC, 32'h0000_005A);
    wait_pin(1'b1);
    repeat (2) @(posedge clk_i);
    xfer(1'b0, tcc_pkg::OFS_IRQ_STATUS, 32'h0);
    chk("overflow", q & 32'h1, 32'h1);
    wait_pin(1'b0);
    xfer(1'b1, tcc_pkg::OFS_CH1_SC, 32'h0000_0054);
    wait_pin(1'b1);
    wait_pin(1'b0);
    $display("compare test done");
  endtask : t_compare
  task automatic t_unbuf;
    xfer(1'b1, tcc_pkg::OFS_CH1_LOW, 32'h0000_0030);
    xfer(1'b1, tcc_pkg::OFS_CTRL, 32'h0000_0030);
    xfer(1'b1, tcc_pkg::OFS_CTRL, 32'h0000_0000);
    repeat (10) @(posedge clk_i);
    xfer(1'b1, tcc_pkg::OFS_CTRL, 32'h0000_0020);
    xfer(1'b0, tcc_pkg::OFS_COUNT, 32'h0);
    // new value sits behind the stopped counter, old one ahead of it
    xfer(1'b1, tcc_pkg::OFS_CH1_LOW, q - 32'h1);
    xfer(1'b0, tcc_pkg::OFS_IRQ_STATUS, 32'h0);
    xfer(1'b1, tcc_pkg::OFS_CTRL, 32'h0000_0000);
    repeat (40) @(posedge clk_i);
    rd_chk("no match", tcc_pkg::OFS_IRQ_STATUS, 32'h0000_0000);
    repeat (30) @(posedge clk_i);
    rd_chk("late match", tcc_pkg::OFS_IRQ_STATUS, 32'h0000_0005);
    $display("unbuffered test done");
  endtask : t_unbuf
  task automatic wait_irq;
    int n;
    n = 0;
    while (irq_o !== 1'b1 && n < 300)
    begin
      @(posedge clk_i);
      n++;
    end
    chk("irq", {31'h0, irq_o}, 32'h1);
  endtask : wait_irq
  // software moves the compare value only from the matching interrupt routine
  task automatic t_sync;
    xfer(1'b1, tcc_pkg::OFS_CH1_LOW, 32'h0000_0030);
    xfer(1'b1, tcc_pkg::OFS_IRQ_MASK, 32'h0000_0004);
    xfer(1'b0, tcc_pkg::OFS_IRQ_STATUS, 32'h0);
    wait_irq();
    // smaller value, written in the compare interrupt routine
    xfer(1'b1, tcc_pkg::OFS_CH1_LOW, 32'h0000_0008);
    xfer(1'b0, tcc_pkg::OFS_IRQ_STATUS, 32'h0);
    chk("sync cmp flag", q & 32'h4, 32'h4);
    repeat (12) @(posedge clk_i);
    rd_chk("sync small none", tcc_pkg::OFS_IRQ_STATUS, 32'h0000_0001);
    repeat (12) @(posedge clk_i);
    rd_chk("sync small match", tcc_pkg::OFS_IRQ_STATUS, 32'h0000_0004);
    xfer(1'b1, tcc_pkg::OFS_IRQ_MASK, 32'h0000_0001);
    xfer(1'b0, tcc_pkg::OFS_IRQ_STATUS, 32'h0);
    wait_irq();
    // larger value, written in the overflow interrupt routine
    xfer(1'b1, tcc_pkg::OFS_CH1_LOW, 32'h0000_0030);
    xfer(1'b0, tcc_pkg::OFS_IRQ_STATUS, 32'h0);
    chk("sync ovf flag", q & 32'h1, 32'h1);
    repeat (20) @(posedge clk_i);
    rd_chk("sync large none", tcc_pkg::OFS_IRQ_STATUS, 32'h0000_0000);
    repeat (30) @(posedge clk_i);
    rd_chk("sync large match", tcc_pkg::OFS_IRQ_STATUS, 32'h0000_0004);
    $display("sync test done");
  endtask : t_sync
  initial
  begin
    repeat (10) @(posedge clk_i);
    resetn_i <= 1'b1;
    t_reset();
    t_prescale();
    t_capture();
    t_compare();
    t_unbuf();
    t_sync();
    finish_test();
  end
endmodule : tb_top
